/* hdl/gpmc_pkg.sv */
// constants, field layout and state codes of the pad mode control block
// assumes an 8-bit special-function-register bus on the cpu clock
package gpmc_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PAD_OPTION_CONTROL  = 8'hb5;
  localparam logic [7:0] ADDR_PIN_FUNCTION_SETUP  = 8'hb6;

  // ----------------------------------------------------------------
  // pad_option_control fields
  // ----------------------------------------------------------------
  localparam int         POC_STROBE_BIT          = 7;
  localparam int         POC_ROFF_BIT            = 6;
  localparam int         POC_MATRIX_BIT          = 5;
  localparam int         POC_DOUBLE_DRIVE_BIT    = 4;
  localparam int         POC_PIN5_TRIP_BIT       = 3;
  localparam int         POC_INPUT_TRIP_BIT      = 2;
  localparam int         POC_LED_LSB             = 0;
  localparam logic [7:0] POC_RESET               = 8'h0c;
  localparam logic [1:0] PAD_LATCH_RESET         = 2'h0;
  localparam logic [1:0] LED_LEVEL_OFF           = 2'h0;

  // ----------------------------------------------------------------
  // pin_function_setup fields
  // ----------------------------------------------------------------
  localparam int         PFS_IRQ1_ANY_BIT        = 7;
  localparam int         PFS_IRQ0_ANY_BIT        = 6;
  localparam int         PFS_CLKOUT_SEL_LSB      = 4;
  localparam int         PFS_CLKOUT_EN_BIT       = 3;
  localparam int         PFS_REF_EN_BIT          = 2;
  localparam logic [7:0] PFS_RESET               = 8'h00;

  // ----------------------------------------------------------------
  // pins and timing
  // ----------------------------------------------------------------
  localparam int         PIN_INPUT_ONLY          = 0;
  localparam int         PIN_ROFF_LO             = 1;
  localparam int         PIN_ROFF_HI             = 2;
  localparam int         PIN_MATRIX_HI           = 3;
  localparam int         PIN_REF_CLK             = 3;
  localparam int         PIN_CLKOUT_A            = 4;
  localparam int         PIN_LED                 = 5;
  localparam int         PIN_CLKOUT_B            = 6;
  localparam int         STROBE_FINISH_CYCLES    = 2;

  typedef enum logic [2:0]
  {
    GPMC_LAT_HOLD   = 3'b001,
    GPMC_LAT_OPEN   = 3'b010,
    GPMC_LAT_FINISH = 3'b100
  } gpmc_lat_state_t;

endpackage

/* hdl/gpmc_edge_detect.sv */
// edge detector for one external interrupt source
// assumes the source level is already synchronised to sys_clk
`timescale 1ns/1ps
`default_nettype none
module gpmc_edge_detect
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic level_in,
  input  wire logic any_edge,
  input  wire logic falling_sel,
  output logic      irq_pulse
);

  logic level_prev_reg;
  logic rise;
  logic fall;

  // ----------------------------------------------------------------
  // edge selection
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      level_prev_reg <= 1'b0;
    else
      level_prev_reg <= level_in;
  end

  assign rise = level_in & ~level_prev_reg;
  assign fall = ~level_in & level_prev_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      irq_pulse <= 1'b0;
    else if (any_edge)
      irq_pulse <= rise | fall;
    else
      irq_pulse <= falling_sel ? fall : rise;
  end

endmodule
`default_nettype wire

/* hdl/gpmc_pad_latch.sv */
// model of the pad mode latches behind the strobe bit
// assumes strobe and data come from registers on sys_clk
`timescale 1ns/1ps
`default_nettype none
module gpmc_pad_latch
#(
  parameter int WIDTH = 2
)
(
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             strobe,
  input  wire logic [WIDTH-1:0] mode_in,
  output logic      [WIDTH-1:0] mode_held,
  output logic                  busy
);

  gpmc_pkg::gpmc_lat_state_t state_reg;
  logic [1:0]                cnt_reg;

  // ----------------------------------------------------------------
  // strobe sequence
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_reg <= gpmc_pkg::GPMC_LAT_HOLD;
      cnt_reg   <= 2'h0;
    end
    else
    begin
      unique case (state_reg)
        gpmc_pkg::GPMC_LAT_HOLD:
        begin
          if (strobe)
            state_reg <= gpmc_pkg::GPMC_LAT_OPEN;
        end
        gpmc_pkg::GPMC_LAT_OPEN:
        begin
          cnt_reg <= 2'h1; // open cycle after the clear is the first finish clock
          if (!strobe)
            state_reg <= gpmc_pkg::GPMC_LAT_FINISH;
        end
        gpmc_pkg::GPMC_LAT_FINISH:
        begin
          cnt_reg <= cnt_reg + 2'h1;
          if (strobe)
            state_reg <= gpmc_pkg::GPMC_LAT_OPEN;
          else if (cnt_reg == 2'(gpmc_pkg::STROBE_FINISH_CYCLES - 1))
            state_reg <= gpmc_pkg::GPMC_LAT_HOLD;
        end
        default:
          state_reg <= gpmc_pkg::GPMC_LAT_HOLD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // latch contents
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      mode_held <= gpmc_pkg::PAD_LATCH_RESET[WIDTH-1:0];
    else if (strobe || state_reg != gpmc_pkg::GPMC_LAT_HOLD)
      mode_held <= mode_in;
  end
  // held otherwise

  assign busy = strobe || (state_reg != gpmc_pkg::GPMC_LAT_HOLD);

endmodule
`default_nettype wire

/* hdl/gpmc_top.sv */
// pad mode control: two option registers on the sfr bus and the pad drive logic
// assumes port0 data/config registers, clock divider and irq polarity bits
// live outside on the same sys_clk; pad inputs and irq sources are asynchronous
`timescale 1ns/1ps
`default_nettype none
module gpmc_top
#(
  parameter int PINS = 8
)
(
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  // sfr bus
  input  wire logic [7:0]      sfr_addr,
  input  wire logic [7:0]      sfr_wdata,
  input  wire logic            sfr_wr,
  input  wire logic            sfr_rd,
  output logic      [7:0]      sfr_rdata,
  // companion registers outside this block
  input  wire logic [PINS-1:0] port0_data_register,
  input  wire logic [PINS-1:0] port0_drive_config,
  input  wire logic            ext_irq0_falling_sel,
  input  wire logic            ext_irq1_falling_sel,
  // clock generator
  input  wire logic            gen_clk_wave,
  input  wire logic            gen_clk_period_start,
  output logic                 clkout_idle,
  // pads
  input  wire logic [PINS-1:0] pad_in,
  input  wire logic            ext_irq0_src,
  input  wire logic            ext_irq1_src,
  output logic      [PINS-1:0] pad_out,
  output logic      [PINS-1:0] pad_oe,
  output logic      [PINS-1:0] pad_pullup_en,
  output logic      [PINS-1:0] pad_trip_mid,
  output logic                 double_drive,
  output logic      [1:0]      led_current_level,
  output logic                 led_on,
  output logic                 ref_clk_in,
  output logic                 strobe_busy,
  output logic                 roff_mode,
  output logic                 matrix_mode,
  output logic      [PINS-1:0] pad_in_sync,
  output logic                 ext_irq0,
  output logic                 ext_irq1
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]      poc_reg;
  logic [7:0]      pfs_reg;
  logic [1:0]      mode_held;
  logic            wr_poc;
  logic            wr_pfs;
  logic [PINS-1:0] pad_meta_reg;
  logic [PINS-1:0] pad_sync_reg;
  logic [1:0]      irq_meta_reg;
  logic [1:0]      irq_sync_reg;
  logic            clk_gate_reg;
  logic            clk_wave_reg;
  logic            clkout_en;
  logic [1:0]      clkout_sel;
  logic [PINS-1:0] out_next;
  logic [PINS-1:0] oe_next;
  logic [PINS-1:0] pull_next;
  logic [PINS-1:0] trip_next;
  logic [7:0]      rdata_next;
  logic [1:0]      led_level;
  logic            led_enable;

  assign wr_poc     = sfr_wr && (sfr_addr == gpmc_pkg::ADDR_PAD_OPTION_CONTROL);
  assign wr_pfs     = sfr_wr && (sfr_addr == gpmc_pkg::ADDR_PIN_FUNCTION_SETUP);
  assign clkout_en  = pfs_reg[gpmc_pkg::PFS_CLKOUT_EN_BIT];
  assign clkout_sel = pfs_reg[gpmc_pkg::PFS_CLKOUT_SEL_LSB +: 2];
  assign led_level  = poc_reg[gpmc_pkg::POC_LED_LSB +: 2];
  assign led_enable = led_level != gpmc_pkg::LED_LEVEL_OFF;

  // ----------------------------------------------------------------
  // option registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      poc_reg <= gpmc_pkg::POC_RESET;
    else if (wr_poc)
      poc_reg <= sfr_wdata;
  end

  // reserved low bits are stored as written; software keeps them 0
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pfs_reg <= gpmc_pkg::PFS_RESET;
    else if (wr_pfs)
      pfs_reg <= sfr_wdata;
  end

  // ----------------------------------------------------------------
  // pad mode latches
  // ----------------------------------------------------------------
  gpmc_pad_latch
  #(
    .WIDTH (2)
  )
  u_pad_latch
  (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .strobe    (poc_reg[gpmc_pkg::POC_STROBE_BIT]),
    .mode_in   ({poc_reg[gpmc_pkg::POC_ROFF_BIT], poc_reg[gpmc_pkg::POC_MATRIX_BIT]}),
    .mode_held (mode_held),
    .busy      (strobe_busy)
  );

  assign roff_mode   = mode_held[1];
  assign matrix_mode = mode_held[0];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = 8'h00;
    if (sfr_addr == gpmc_pkg::ADDR_PAD_OPTION_CONTROL)
    begin
      rdata_next = poc_reg;
      rdata_next[gpmc_pkg::POC_ROFF_BIT]   = roff_mode;
      rdata_next[gpmc_pkg::POC_MATRIX_BIT] = matrix_mode;
    end
    else if (sfr_addr == gpmc_pkg::ADDR_PIN_FUNCTION_SETUP)
    begin
      rdata_next = pfs_reg;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
      sfr_rdata <= rdata_next;
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pad_meta_reg <= '0;
      pad_sync_reg <= '0;
    end
    else
    begin
      pad_meta_reg <= pad_in;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      irq_meta_reg <= 2'h0;
      irq_sync_reg <= 2'h0;
    end
    else
    begin
      irq_meta_reg <= {ext_irq1_src, ext_irq0_src};
      irq_sync_reg <= irq_meta_reg;
    end
  end

  assign pad_in_sync = pad_sync_reg;
  assign ref_clk_in  = pad_sync_reg[gpmc_pkg::PIN_REF_CLK] &
                       pfs_reg[gpmc_pkg::PFS_REF_EN_BIT];

  // ----------------------------------------------------------------
  // external interrupt edges
  // ----------------------------------------------------------------
  gpmc_edge_detect u_irq0
  (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .level_in    (irq_sync_reg[0]),
    .any_edge    (pfs_reg[gpmc_pkg::PFS_IRQ0_ANY_BIT]),
    .falling_sel (ext_irq0_falling_sel),
    .irq_pulse   (ext_irq0)
  );

  gpmc_edge_detect u_irq1
  (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .level_in    (irq_sync_reg[1]),
    .any_edge    (pfs_reg[gpmc_pkg::PFS_IRQ1_ANY_BIT]),
    .falling_sel (ext_irq1_falling_sel),
    .irq_pulse   (ext_irq1)
  );

  // ----------------------------------------------------------------
  // clock output gate
  // ----------------------------------------------------------------
  // gate only changes at a period start, so a running period is finished
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      clk_gate_reg <= 1'b0;
    else if (gen_clk_period_start)
      clk_gate_reg <= clkout_en;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      clk_wave_reg <= 1'b0;
    else
      clk_wave_reg <= gen_clk_wave & clk_gate_reg;
  end

  assign clkout_idle = ~clk_gate_reg;

  // ----------------------------------------------------------------
  // pad drive
  // ----------------------------------------------------------------
  always_comb
  begin
    out_next  = '0;
    oe_next   = '0;
    pull_next = '0;
    trip_next = '0;
    for (int i = 0; i < PINS; i++)
    begin
      // open drain drives low only, push-pull always drives
      out_next[i]  = port0_data_register[i];
      oe_next[i]   = port0_drive_config[i] | ~port0_data_register[i];
      pull_next[i] = ~port0_drive_config[i];
      trip_next[i] = poc_reg[gpmc_pkg::POC_INPUT_TRIP_BIT];
    end
    trip_next[gpmc_pkg::PIN_LED] = poc_reg[gpmc_pkg::POC_PIN5_TRIP_BIT];
    out_next[gpmc_pkg::PIN_INPUT_ONLY] = 1'b0;
    oe_next[gpmc_pkg::PIN_INPUT_ONLY]  = 1'b0;
    out_next[gpmc_pkg::PIN_LED]        = 1'b0;
    oe_next[gpmc_pkg::PIN_LED]         = 1'b0;
    if (roff_mode)
    begin
      for (int i = gpmc_pkg::PIN_ROFF_LO; i <= gpmc_pkg::PIN_ROFF_HI; i++)
        pull_next[i] = 1'b0;
    end
    if (matrix_mode)
    begin
      for (int i = gpmc_pkg::PIN_ROFF_LO; i <= gpmc_pkg::PIN_MATRIX_HI; i++)
      begin
        out_next[i]  = 1'b0;
        oe_next[i]   = 1'b1;
        pull_next[i] = 1'b0;
      end
    end
    if (clkout_sel[0])
    begin
      out_next[gpmc_pkg::PIN_CLKOUT_A]  = clk_wave_reg;
      oe_next[gpmc_pkg::PIN_CLKOUT_A]   = 1'b1;
      pull_next[gpmc_pkg::PIN_CLKOUT_A] = 1'b0;
    end
    if (clkout_sel[1])
    begin
      out_next[gpmc_pkg::PIN_CLKOUT_B]  = clk_wave_reg;
      oe_next[gpmc_pkg::PIN_CLKOUT_B]   = 1'b1;
      pull_next[gpmc_pkg::PIN_CLKOUT_B] = 1'b0;
    end
    if (pfs_reg[gpmc_pkg::PFS_REF_EN_BIT])
    begin
      out_next[gpmc_pkg::PIN_REF_CLK] = 1'b0;
      oe_next[gpmc_pkg::PIN_REF_CLK]  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pad drive registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pad_out <= '0;
    else
      pad_out <= out_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pad_oe <= '0;
    else
      pad_oe <= oe_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pad_pullup_en <= '0;
    else
      pad_pullup_en <= pull_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pad_trip_mid <= '0;
    else
      pad_trip_mid <= trip_next;
  end

  // ----------------------------------------------------------------
  // drive strength
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      double_drive <= 1'b0;
    else
      double_drive <= poc_reg[gpmc_pkg::POC_DOUBLE_DRIVE_BIT];
  end

  // ----------------------------------------------------------------
  // led current and switching
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      led_current_level <= gpmc_pkg::LED_LEVEL_OFF;
    else
      led_current_level <= led_level;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      led_on <= 1'b0;
    else
      led_on <= port0_data_register[gpmc_pkg::PIN_LED] & led_enable;
  end

endmodule
`default_nettype wire

/* tb/gpmc_props.sv */
// assertion checker for gpmc_top, attached by bind
// sees only top ports; register state is shadowed from sfr writes
`timescale 1ns/1ps
`default_nettype none
module gpmc_props
#(
  parameter int PINS = 8
)
(
  input wire logic            sys_clk,
  input wire logic            rstn,
  input wire logic [7:0]      sfr_addr,
  input wire logic [7:0]      sfr_wdata,
  input wire logic            sfr_wr,
  input wire logic [PINS-1:0] port0_data_register,
  input wire logic            gen_clk_period_start,
  input wire logic            clkout_idle,
  input wire logic [PINS-1:0] pad_out,
  input wire logic [PINS-1:0] pad_oe,
  input wire logic [PINS-1:0] pad_pullup_en,
  input wire logic [PINS-1:0] pad_trip_mid,
  input wire logic            double_drive,
  input wire logic [1:0]      led_current_level,
  input wire logic            led_on,
  input wire logic            strobe_busy,
  input wire logic            roff_mode,
  input wire logic            matrix_mode
);
  wire logic  poc_wr = sfr_wr && sfr_addr == gpmc_pkg::ADDR_PAD_OPTION_CONTROL;
  wire logic  pfs_wr = sfr_wr && sfr_addr == gpmc_pkg::ADDR_PIN_FUNCTION_SETUP;
  logic [7:0] poc_seen;
  logic [7:0] pfs_seen;
  // ------
  // register shadows
  // ------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      poc_seen <= gpmc_pkg::POC_RESET;
    else if (poc_wr)
      poc_seen <= sfr_wdata;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pfs_seen <= gpmc_pkg::PFS_RESET;
    else if (pfs_wr)
      pfs_seen <= sfr_wdata;
  end
  // ------
  // checks
  // ------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  sequence finish_tail;
    strobe_busy [*2] ##1 !strobe_busy;
  endsequence
  chk_latch_open:
    assert property ($past(poc_seen[7]) |-> {roff_mode, matrix_mode} == $past(poc_seen[6:5]))
    else $error("latch not following modes");
  chk_strobe_finish:
    assert property (poc_wr && !sfr_wdata[7] && poc_seen[7] |=> finish_tail)
    else $error("strobe finish length");
  chk_latch_hold:
    assert property (!strobe_busy |=> $stable(roff_mode) && $stable(matrix_mode))
    else $error("latch changed while closed");
  chk_roff_pullup:
    assert property (roff_mode && $past(roff_mode) |-> pad_pullup_en[2:1] == 2'h0)
    else $error("pull-up on in roff mode");
  chk_matrix_low:
    assert property (matrix_mode && $past(matrix_mode) |-> pad_oe[2:1] == 2'h3
      && pad_out[2:1] == 2'h0 && pad_pullup_en[2:1] == 2'h0)
    else $error("matrix pins not low");
  chk_option_out:
    assert property (poc_wr |=> ##1 double_drive == $past(sfr_wdata[4], 2)
      && pad_trip_mid[5:4] == $past(sfr_wdata[3:2], 2)
      && led_current_level == $past(sfr_wdata[1:0], 2))
    else $error("option outputs wrong");
  chk_led_follow:
    assert property (led_current_level != 2'h0 || !$past(port0_data_register[5])
      |-> led_on == $past(port0_data_register[5]))
    else $error("led not following data bit");
  chk_clkout_route:
    assert property (pfs_wr |=> ##1 (!$past(sfr_wdata[4], 2) || pad_oe[4])
      && (!$past(sfr_wdata[5], 2) || pad_oe[6]))
    else $error("clock pin not enabled");
  chk_gate_period:
    assert property ($changed(clkout_idle) |-> $past(gen_clk_period_start))
    else $error("gate moved mid period");
  chk_clkout_stop:
    assert property ($past(pfs_seen[4]) && $past(clkout_idle) |-> !pad_out[4])
    else $error("idle clock not low");
  chk_ref_input:
    assert property ($past(pfs_seen[2]) |-> !pad_oe[3])
    else $error("ref pin driven");
endmodule
bind gpmc_top gpmc_props #(.PINS(PINS)) u_props (.*);
`default_nettype wire

/* tb/gpmc_pads.sv */
// pad and clock divider model at the pad side of gpmc_top
// pins settle from bench drive, design drive, pull-up, else they float
`timescale 1ns/1ps
`default_nettype none
module gpmc_pads
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup_en,
  input  wire logic [7:0] ext_drv,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_in,
  output wire logic       gen_clk_wave,
  output wire logic       gen_clk_period_start
);
  logic [7:0] last = 8'h00;
  logic [1:0] div  = 2'h0;
  // ------
  // pin levels and divider
  // ------
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (ext_drv[i])
        pad_in[i] = ext_val[i];
      else if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (pad_pullup_en[i])
        pad_in[i] = 1'b1;
      else
        pad_in[i] = ~last[i];
    end
  end
  always @(posedge sys_clk)
  begin
    last <= pad_in;
    div <= div + 2'h1;
  end
  assign gen_clk_wave = div[1];
  assign gen_clk_period_start = (div == 2'h0);
endmodule
`default_nettype wire

/* tb/gpmc_top_tb.sv */
// self-checking bench for gpmc_top with the pad model
// inputs change on the falling edge; registers reached over the sfr bus
`timescale 1ns/1ps
`default_nettype none
module gpmc_top_tb;
  logic       sys_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] port0_data_register = 8'hff;
  logic [7:0] port0_drive_config = 8'h00;
  logic       ext_irq0_falling_sel = 1'b0;
  logic       ext_irq1_falling_sel = 1'b0;
  logic       ext_irq0_src = 1'b0;
  logic       ext_irq1_src = 1'b0;
  logic [7:0] ext_drv = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] sfr_rdata, pad_in, pad_out, pad_oe, pad_pullup_en, pad_trip_mid, pad_in_sync;
  logic [1:0] led_current_level;
  logic       gen_clk_wave, gen_clk_period_start, clkout_idle, double_drive, led_on;
  logic       ref_clk_in, strobe_busy, roff_mode, matrix_mode, ext_irq0, ext_irq1;
  int         failures = 0;
  int         tests_run = 0;
  int         cycles = 0;
  gpmc_top DUT (.*);
  gpmc_pads u_pads (.*);
  always #50 sys_clk = ~sys_clk;
  // ------
  // helpers
  // ------
  task automatic wrap_up;
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    chk("sfr_rdata", e, sfr_rdata);
    cyc(1);
  endtask
  task automatic strobe(input logic [7:0] d);
    wr(8'hb5, d | 8'h80);
    wr(8'hb5, d);
    chk("busy", 8'h01, strobe_busy);
    cyc(1);
    chk("busy", 8'h00, strobe_busy);
    cyc(2);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_reset;
    cyc(1);
    chk("trip", 8'hff, pad_trip_mid);
    rd(8'hb5, 8'h0c);
    rd(8'hb6, 8'h00);
    wr(8'hb7, 8'hff);
    rd(8'hb7, 8'h00);
    rd(8'hb6, 8'h00);
  endtask
  task automatic t_strobe;
    strobe(8'h40);
    chk("roff", 8'h01, roff_mode);
    chk("pullup", 8'h00, pad_pullup_en & 8'h06);
    chk("oe", 8'h00, pad_oe & 8'h06);
    wr(8'hb5, 8'h20);
    rd(8'hb5, 8'h40);
    strobe(8'h20);
    chk("matrix", 8'h01, matrix_mode);
    rd(8'hb5, 8'h20);
    cyc(2);
    chk("oe", 8'h0e, pad_oe & 8'h0e);
    chk("out", 8'h00, pad_out & 8'h0e);
    chk("pin", 8'h00, pad_in_sync & 8'h0e);
    strobe(8'h00);
    chk("pullup", 8'h06, pad_pullup_en & 8'h06);
  endtask
  task automatic t_options;
    port0_data_register[5] = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'hb5, 8'h18 | 8'(i));
      chk("led_level", 8'(i), led_current_level);
      if (i != 0)
        chk("led_on", 8'h01, led_on);
      else
        chk("led_on", 8'h00, led_on);
    end
    chk("drive", 8'h01, double_drive);
    chk("trip", 8'h20, pad_trip_mid & 8'h30);
    port0_data_register[5] = 1'b0;
    cyc(2);
    chk("led_on", 8'h00, led_on);
    wr(8'hb5, 8'h04);
    chk("trip", 8'h10, pad_trip_mid & 8'h30);
    chk("drive", 8'h00, double_drive);
  endtask
  task automatic t_clkout;
    logic [7:0] n;
    n = 8'h00;
    wr(8'hb6, 8'h08);
    chk("oe46", 8'h00, pad_oe & 8'h50);
    wr(8'hb6, 8'h38);
    chk("oe46", 8'h50, pad_oe & 8'h50);
    repeat (16)
    begin
      cyc(1);
      n += 8'(pad_out[4] & pad_out[6]);
    end
    chk("clk_run", 8'h01, 8'(n != 8'h00));
    wr(8'hb6, 8'h30);
    for (int k = 0; k < 20 && clkout_idle !== 1'b1; k++)
      cyc(1);
    chk("idle", 8'h01, clkout_idle);
    cyc(2);
    repeat (8)
    begin
      chk("clk_stop", 8'h00, pad_out & 8'h50);
      cyc(1);
    end
    chk("oe46", 8'h50, pad_oe & 8'h50);
  endtask
  task automatic t_ref;
    port0_drive_config[3] = 1'b1;
    port0_data_register[3] = 1'b0;
    ext_drv[3] = 1'b1;
    wr(8'hb6, 8'h04);
    for (int v = 0; v < 2; v++)
    begin
      ext_val[3] = v[0];
      cyc(4);
      chk("ref", 8'(v), ref_clk_in);
    end
    chk("oe3", 8'h00, pad_oe & 8'h08);
    ext_drv[3] = 1'b0;
    wr(8'hb6, 8'h00);
    chk("oe3", 8'h08, pad_oe & 8'h08);
  endtask
  task automatic t_irq;
    logic [7:0] c0;
    logic [7:0] c1;
    for (int m = 0; m < 4; m++)
    begin
      ext_irq0_falling_sel = m[1];
      ext_irq1_falling_sel = !m[1];
      wr(8'hb6, {m[0], !m[0], 6'h00});
      for (int e = 0; e < 2; e++)
      begin
        ext_irq0_src = !e[0];
        ext_irq1_src = !e[0];
        c0 = 8'h00;
        c1 = 8'h00;
        repeat (8)
        begin
          cyc(1);
          c0 += 8'(ext_irq0);
          c1 += 8'(ext_irq1);
        end
        chk("irq0", 8'(!m[0] | (m[1] == e[0])), c0);
        chk("irq1", 8'(m[0] | (m[1] != e[0])), c1);
      end
    end
  endtask
  // ------
  // run
  // ------
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      wrap_up;
    end
  end
  initial
  begin
    cyc(3);
    rstn = 1'b1;
    t_reset;
    t_strobe;
    t_options;
    t_clkout;
    t_ref;
    t_irq;
    wrap_up;
  end
endmodule
`default_nettype wire
